// ==== oarb_reg_bank.sv ====
`default_nettype none
module oarb_reg_bank
    import oarb_pkg::*;
(
    input wire logic clk,
    input wire logic reset_n,
    input wire logic ce,
    input wire oarb_reg_req_type regReq,
    output logic [7:0] regReadData,
    output logic regReadValid,
    input wire logic manualOffsetMode,
    input wire logic blackCalEnable,
    input wire logic rawRgbMode,
    input wire logic calUpdate,
    input wire logic [7:0] calLumaOffset,
    input wire logic [7:0] calChromaOffset,
    input wire oarb_pixel_type pixIn,
    input wire logic frameEnd,
    output oarb_pixel_type pixOut,
    output oarb_ae_dir_type aeDirection,
    output logic aeDecisionValid,
    output logic [1:0] crystalPowerLevel,
    output logic [5:0] refVoltageSteps
);
    logic [7:0] lumaOfs_ff;
    logic [7:0] chromaOfs_ff;
    logic [7:0] refCtrl_ff;
    logic [7:0] brightRatio_ff;
    logic [7:0] darkRatio_ff;
    logic [5:0] refVoltageSteps_ff;
    logic [7:0] regReadData_ff;
    logic regReadValid_ff;
    logic chromaIsU_ff;
    logic [CNT_W-1:0] brightCnt_ff;
    logic [CNT_W-1:0] darkCnt_ff;
    logic [CNT_W-1:0] totalCnt_ff;
    oarb_ae_dir_type aeDirection_ff;
    oarb_ae_dir_type nxt_aeDirection;
    logic aeDecisionValid_ff;
    logic [7:0] nxt_readData;

    // Write decode
    logic hostWrite;
    logic wrLuma;
    logic wrChroma;
    logic wrRefCtrl;
    logic wrBright;
    logic wrDark;
    logic autoLoad;

    assign hostWrite = ce && regReq.write;
    // Host may only steer offsets in manual mode
    assign wrLuma = hostWrite && manualOffsetMode && (regReq.addr == ADDR_LUMA_OFS); // [R03] [R04] [R16]
    assign wrChroma = hostWrite && manualOffsetMode && (regReq.addr == ADDR_CHROMA_OFS); // [R08]
    assign wrRefCtrl = hostWrite && (regReq.addr == ADDR_REF_CTRL);
    assign wrBright = hostWrite && (regReq.addr == ADDR_BRIGHT_RATIO);
    assign wrDark = hostWrite && (regReq.addr == ADDR_DARK_RATIO);
    // Calibration only owns the offsets outside manual mode
    assign autoLoad = ce && calUpdate && !manualOffsetMode; // [R03] [R08] [R16]

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            lumaOfs_ff <= RST_LUMA_OFS;
        end else if (autoLoad) begin
            lumaOfs_ff <= calLumaOffset; // [R03]
        end else if (wrLuma) begin
            lumaOfs_ff <= regReq.data; // [R04]
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            chromaOfs_ff <= RST_CHROMA_OFS;
        end else if (autoLoad) begin
            chromaOfs_ff <= calChromaOffset; // [R08]
        end else if (wrChroma) begin
            chromaOfs_ff <= regReq.data; // [R08]
        end
    end

    // Bits 5:4 kept only for read back
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            refCtrl_ff <= RST_REF_CTRL;
            refVoltageSteps_ff <= VREF_BASE_STEPS + 6'(RST_REF_CTRL[VREF_MSB:0]);
        end else if (wrRefCtrl) begin
            refCtrl_ff <= regReq.data; // [R19]
            refVoltageSteps_ff <= VREF_BASE_STEPS + 6'(regReq.data[VREF_MSB:0]); // [R11]
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            brightRatio_ff <= RST_BRIGHT_RATIO;
        end else if (wrBright) begin
            brightRatio_ff <= regReq.data; // [R13]
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            darkRatio_ff <= RST_DARK_RATIO;
        end else if (wrDark) begin
            darkRatio_ff <= regReq.data; // [R18]
        end
    end

    // Read mux, unmapped subaddresses return zero
    always_comb begin
        if (regReq.addr == ADDR_LUMA_OFS) begin
            nxt_readData = lumaOfs_ff;
        end else if (regReq.addr == ADDR_CHROMA_OFS) begin
            nxt_readData = chromaOfs_ff;
        end else if (regReq.addr == ADDR_REF_CTRL) begin
            nxt_readData = refCtrl_ff;
        end else if (regReq.addr == ADDR_BRIGHT_RATIO) begin
            nxt_readData = brightRatio_ff;
        end else if (regReq.addr == ADDR_DARK_RATIO) begin
            nxt_readData = darkRatio_ff;
        end else begin
            nxt_readData = 8'h00;
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            regReadData_ff <= 8'h00;
            regReadValid_ff <= 1'b0;
        end else if (ce) begin
            regReadValid_ff <= regReq.read;
            if (regReq.read) begin
                regReadData_ff <= nxt_readData;
            end
        end
    end

    // Offset application
    logic lumaApply;
    logic chromaApply;
    logic [7:0] lumaOut;
    logic [7:0] chromaOut;
    logic pixValidOut;

    assign lumaApply = blackCalEnable; // [R05] [R17]
    // Chroma acts only while calibration is off, unlike luma; raw mode adjusts R and B alike
    assign chromaApply = !blackCalEnable && (rawRgbMode || pixIn.chromaIsU); // [R09] [R06]

    oarb_offset_apply u_luma (
        .clk(clk),
        .reset_n(reset_n),
        .ce(ce),
        .inValid(pixIn.valid),
        .inData(pixIn.luma),
        .offset(lumaOfs_ff),
        .apply(lumaApply),
        .outValid(pixValidOut),
        .outData(lumaOut)
    );

    oarb_offset_apply u_chroma (
        .clk(clk),
        .reset_n(reset_n),
        .ce(ce),
        .inValid(pixIn.valid),
        .inData(pixIn.chroma),
        .offset(chromaOfs_ff),
        .apply(chromaApply),
        .outValid(),
        .outData(chromaOut)
    );

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            chromaIsU_ff <= 1'b0;
        end else if (ce && pixIn.valid) begin
            chromaIsU_ff <= pixIn.chromaIsU;
        end
    end

    // Exposure statistics
    logic isBright;
    logic isDark;
    logic [CNT_W-1:0] brightInc;
    logic [CNT_W-1:0] darkInc;
    logic [CNT_W-1:0] totalInc;

    assign isBright = pixIn.valid && (pixIn.luma > BRIGHT_LEVEL); // [R12]
    assign isDark = pixIn.valid && (pixIn.luma < DARK_LEVEL); // [R12]
    assign brightInc = CNT_W'(isBright);
    assign darkInc = CNT_W'(isDark);
    assign totalInc = CNT_W'(pixIn.valid);

    // Counters are wide enough for one full frame; they are not saturated
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            brightCnt_ff <= '0;
            darkCnt_ff <= '0;
            totalCnt_ff <= '0;
        end else if (ce && frameEnd) begin
            brightCnt_ff <= brightInc;
            darkCnt_ff <= darkInc;
            totalCnt_ff <= totalInc;
        end else if (ce) begin
            brightCnt_ff <= brightCnt_ff + brightInc;
            darkCnt_ff <= darkCnt_ff + darkInc;
            totalCnt_ff <= totalCnt_ff + totalInc;
        end
    end

    logic [7:0] brightEff;
    logic [7:0] darkEff;
    logic [PROD_W-1:0] brightScaled;
    logic [PROD_W-1:0] darkScaled;
    logic [PROD_W-1:0] brightTarget;
    logic [PROD_W-1:0] darkTarget;
    logic brightLow;
    logic brightHigh;
    logic darkLow;
    logic darkHigh;

    // Out-of-range ratios are clamped rather than trusted
    assign brightEff = oarb_clamp_ratio(brightRatio_ff); // [R13]
    assign darkEff = oarb_clamp_ratio(darkRatio_ff); // [R18]
    assign brightScaled = oarb_scale(brightCnt_ff, RATIO_STEP_DEN); // [R12]
    assign darkScaled = oarb_scale(darkCnt_ff, RATIO_STEP_DEN);
    assign brightTarget = oarb_scale(totalCnt_ff, brightEff); // [R13]
    assign darkTarget = oarb_scale(totalCnt_ff, darkEff);
    assign brightLow = brightScaled < brightTarget;
    assign brightHigh = brightScaled > brightTarget;
    assign darkLow = darkScaled < darkTarget;
    assign darkHigh = darkScaled > darkTarget;

    // Without the host's sum margin both targets may be unreachable at once
    always_comb begin
        if (brightLow && darkHigh) begin
            nxt_aeDirection = AE_BRIGHTEN; // [R14] [R15]
        end else if (brightHigh && darkLow) begin
            nxt_aeDirection = AE_DARKEN; // [R18]
        end else begin
            nxt_aeDirection = AE_STABLE; // [R12]
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            aeDirection_ff <= AE_STABLE;
            aeDecisionValid_ff <= 1'b0;
        end else if (ce) begin
            aeDecisionValid_ff <= frameEnd;
            if (frameEnd) begin
                aeDirection_ff <= nxt_aeDirection;
            end
        end
    end

    assign regReadData = regReadData_ff;
    assign regReadValid = regReadValid_ff;
    assign pixOut = '{valid: pixValidOut, chromaIsU: chromaIsU_ff,
                      luma: lumaOut, chroma: chromaOut};
    assign aeDirection = aeDirection_ff;
    assign aeDecisionValid = aeDecisionValid_ff;
    assign crystalPowerLevel = refCtrl_ff[XTAL_MSB:XTAL_LSB]; // [R10]
    assign refVoltageSteps = refVoltageSteps_ff;

    // Checks
    property p_luma_add;
        @(posedge clk) disable iff (!reset_n)
        ce && pixIn.valid && blackCalEnable && !lumaOfs_ff[OFS_DIR_BIT]
            |=> pixOut.luma >= $past(pixIn.luma);
    endproperty
    a_luma_add: assert property (p_luma_add) else $error("luma add lowered pixel"); // [R01]

    property p_luma_sub;
        @(posedge clk) disable iff (!reset_n)
        ce && pixIn.valid && blackCalEnable && lumaOfs_ff[OFS_DIR_BIT]
            |=> pixOut.luma <= $past(pixIn.luma);
    endproperty
    a_luma_sub: assert property (p_luma_sub) else $error("luma subtract raised pixel"); // [R01]

    property p_luma_range;
        @(posedge clk) disable iff (!reset_n)
        ce && pixIn.valid && blackCalEnable && !lumaOfs_ff[OFS_DIR_BIT]
            && (pixIn.luma < 8'h80)
            |=> pixOut.luma == $past(pixIn.luma) + {1'b0, $past(lumaOfs_ff[OFS_MAG_MSB:0])};
    endproperty
    a_luma_range: assert property (p_luma_range) else $error("luma magnitude wrong"); // [R02]

    property p_luma_auto_ignore;
        @(posedge clk) disable iff (!reset_n)
        ce && regReq.write && regReq.addr == ADDR_LUMA_OFS && !manualOffsetMode && !calUpdate
            |=> $stable(lumaOfs_ff);
    endproperty
    a_luma_auto_ignore: assert property (p_luma_auto_ignore) else $error("host write took effect"); // [R03]

    property p_luma_manual;
        @(posedge clk) disable iff (!reset_n)
        ce && regReq.write && regReq.addr == ADDR_LUMA_OFS && manualOffsetMode
            |=> lumaOfs_ff == $past(regReq.data);
    endproperty
    a_luma_manual: assert property (p_luma_manual) else $error("manual luma not stored"); // [R04]

    property p_luma_cal_off;
        @(posedge clk) disable iff (!reset_n)
        ce && pixIn.valid && !blackCalEnable |=> pixOut.luma == $past(pixIn.luma);
    endproperty
    a_luma_cal_off: assert property (p_luma_cal_off) else $error("luma adjusted while disabled"); // [R05]

    property p_chroma_manual_hold;
        @(posedge clk) disable iff (!reset_n)
        ce && calUpdate && manualOffsetMode && !regReq.write |=> $stable(chromaOfs_ff);
    endproperty
    a_chroma_manual_hold: assert property (p_chroma_manual_hold)
        else $error("calibration overwrote manual chroma"); // [R08]

    property p_chroma_cal_on;
        @(posedge clk) disable iff (!reset_n)
        ce && pixIn.valid && blackCalEnable |=> pixOut.chroma == $past(pixIn.chroma);
    endproperty
    a_chroma_cal_on: assert property (p_chroma_cal_on) else $error("chroma adjusted while enabled"); // [R09]

    property p_vref;
        @(posedge clk) disable iff (!reset_n)
        wrRefCtrl |=> refVoltageSteps == VREF_BASE_STEPS + 6'($past(regReq.data[VREF_MSB:0]))
            && crystalPowerLevel == $past(regReq.data[XTAL_MSB:XTAL_LSB]);
    endproperty
    a_vref: assert property (p_vref) else $error("reference control mismatch"); // [R10] [R11]

    property p_rsvd_readback;
        @(posedge clk) disable iff (!reset_n)
        wrRefCtrl ##2 (ce && regReq.read && regReq.addr == ADDR_REF_CTRL && !regReq.write)
            |=> regReadData == $past(refCtrl_ff) && regReadValid;
    endproperty
    a_rsvd_readback: assert property (p_rsvd_readback) else $error("reference readback wrong"); // [R19]

    property p_ae_brighten;
        @(posedge clk) disable iff (!reset_n)
        ce && frameEnd && brightLow && darkHigh
            |=> aeDirection == AE_BRIGHTEN && aeDecisionValid;
    endproperty
    a_ae_brighten: assert property (p_ae_brighten) else $error("exposure did not brighten"); // [R12] [R14]

    property p_ae_darken;
        @(posedge clk) disable iff (!reset_n)
        ce && frameEnd && brightHigh && darkLow |=> aeDirection == AE_DARKEN;
    endproperty
    a_ae_darken: assert property (p_ae_darken) else $error("exposure did not darken"); // [R18]

    c_auto_load: cover property (@(posedge clk) disable iff (!reset_n) autoLoad);
    c_manual_write: cover property (@(posedge clk) disable iff (!reset_n)
        wrLuma ##[1:4] wrChroma);
    c_brighten: cover property (@(posedge clk) disable iff (!reset_n)
        aeDecisionValid && aeDirection == AE_BRIGHTEN);
    c_raw_chroma: cover property (@(posedge clk) disable iff (!reset_n)
        ce && pixIn.valid && rawRgbMode && !pixIn.chromaIsU && !blackCalEnable);
endmodule
`default_nettype wire

// ==== oarb_pkg.sv ====
// How it works
// [R01] Luma offset top bit: 0 adds, 1 subtracts
// [R02] Luma magnitude spans plus/minus 127 codes
// [R03] Auto mode: calibration loads luma, host ignored
// [R04] Manual mode: host luma value is applied
// [R05] Calibration disabled: luma offset has no effect
// [R06] Raw RGB: offsets adjust R, G, B
// [R07] Chroma offset sign-magnitude, plus/minus 127 range
// [R08] Chroma offset arbitrated like luma offset
// [R09] Chroma offset inert while calibration enabled
// [R10] Reference bits 7:6 pick crystal power
// [R11] Reference bits 3:0 pick voltage, 62.5mV steps
// [R12] Count bright/dark pixels per frame, compare ratios
// [R13] Bright ratio 1.3% per step, range 01..ca
// [R14] Higher bright ratio gives brighter image
// [R15] Host keeps bright plus dark above ca
// [R16] Manual bit selects host versus internal offsets
// [R17] Calibration enable bit: 1 on, 0 off
// [R18] Dark ratio at 25h, higher darkens image
// [R19] Reference bits 5:4 stored, no effect
`default_nettype none
package oarb_pkg;
    localparam logic [7:0] ADDR_LUMA_OFS = 8'h21;
    localparam logic [7:0] ADDR_CHROMA_OFS = 8'h22;
    localparam logic [7:0] ADDR_REF_CTRL = 8'h23;
    localparam logic [7:0] ADDR_BRIGHT_RATIO = 8'h24;
    localparam logic [7:0] ADDR_DARK_RATIO = 8'h25;

    localparam logic [7:0] RST_LUMA_OFS = 8'h80;
    localparam logic [7:0] RST_CHROMA_OFS = 8'h80;
    localparam logic [7:0] RST_REF_CTRL = 8'h04;
    localparam logic [7:0] RST_BRIGHT_RATIO = 8'h33;
    localparam logic [7:0] RST_DARK_RATIO = 8'h97;

    localparam int OFS_DIR_BIT = 7;
    localparam int OFS_MAG_MSB = 6;
    localparam int XTAL_MSB = 7;
    localparam int XTAL_LSB = 6;
    localparam int VREF_MSB = 3;

    // 2.5 V expressed in 62.5 mV steps
    localparam logic [5:0] VREF_BASE_STEPS = 6'h28;

    localparam logic [7:0] BRIGHT_LEVEL = 8'hc0;
    localparam logic [7:0] DARK_LEVEL = 8'h40;
    // One ratio step is 1/77 of the frame, close to 1.3 percent
    localparam logic [7:0] RATIO_STEP_DEN = 8'h4d;
    localparam logic [7:0] RATIO_MIN = 8'h01;
    localparam logic [7:0] RATIO_MAX = 8'hca;

    localparam int CNT_W = 18;
    localparam int PROD_W = 26;

    typedef struct packed {
        logic valid;
        logic chromaIsU;
        logic [7:0] luma;
        logic [7:0] chroma;
    } oarb_pixel_type;

    typedef struct packed {
        logic write;
        logic read;
        logic [7:0] addr;
        logic [7:0] data;
    } oarb_reg_req_type;

    typedef enum logic [1:0] {
        AE_STABLE = 2'b00,
        AE_BRIGHTEN = 2'b01,
        AE_DARKEN = 2'b10
    } oarb_ae_dir_type;

    function automatic logic [7:0] oarb_apply_offset(input logic [7:0] data,
                                                     input logic [7:0] ofs);
        logic [8:0] sum;
        logic [8:0] mag;
        mag = {2'b00, ofs[OFS_MAG_MSB:0]};
        if (ofs[OFS_DIR_BIT]) begin
            sum = {1'b0, data} - mag;
            oarb_apply_offset = sum[8] ? 8'h00 : sum[7:0];
        end else begin
            sum = {1'b0, data} + mag;
            oarb_apply_offset = sum[8] ? 8'hff : sum[7:0];
        end
    endfunction

    function automatic logic [7:0] oarb_clamp_ratio(input logic [7:0] ratio);
        if (ratio < RATIO_MIN) begin
            oarb_clamp_ratio = RATIO_MIN;
        end else if (ratio > RATIO_MAX) begin
            oarb_clamp_ratio = RATIO_MAX;
        end else begin
            oarb_clamp_ratio = ratio;
        end
    endfunction

    function automatic logic [PROD_W-1:0] oarb_scale(input logic [CNT_W-1:0] cnt,
                                                     input logic [7:0] k);
        oarb_scale = PROD_W'(cnt) * PROD_W'(k);
    endfunction
endpackage
`default_nettype wire

// ==== oarb_offset_apply.sv ====
`default_nettype none
module oarb_offset_apply
    import oarb_pkg::*;
(
    input wire logic clk,
    input wire logic reset_n,
    input wire logic ce,
    input wire logic inValid,
    input wire logic [7:0] inData,
    input wire logic [7:0] offset,
    input wire logic apply,
    output logic outValid,
    output logic [7:0] outData
);
    logic outValid_ff;
    logic [7:0] outData_ff;
    logic [7:0] nxt_outData;

    // Saturating so a large offset never wraps a pixel
    assign nxt_outData = apply ? oarb_apply_offset(inData, offset) : inData; // [R01] [R07]

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            outValid_ff <= 1'b0;
            outData_ff <= 8'h00;
        end else if (ce) begin
            outValid_ff <= inValid;
            if (inValid) begin
                outData_ff <= nxt_outData;
            end
        end
    end

    assign outValid = outValid_ff;
    assign outData = outData_ff;
endmodule
`default_nettype wire

// ==== oarb_host_model.sv ====
`default_nettype none
module oarb_host_model
    import oarb_pkg::*;
(
    input wire logic clk,
    output var oarb_reg_req_type regReq,
    input wire logic [7:0] regReadData,
    input wire logic regReadValid
);
    timeunit 1ns;
    timeprecision 1ps;

    // Idle cycles after each request, to model a slow host
    int idleCycles = 0;

    initial begin
        regReq = '0;
    end

    // Released data shows the inverse, never a stale copy
    task automatic release_bus();
        regReq.write = 1'b0;
        regReq.read = 1'b0;
        regReq.data = ~regReq.data;
        repeat (idleCycles) @(negedge clk);
    endtask

    task automatic wr(input logic [7:0] addr, input logic [7:0] data);
        @(negedge clk);
        regReq = '{write: 1'b1, read: 1'b0, addr: addr, data: data};
        @(negedge clk);
        release_bus();
    endtask

    task automatic rd(input logic [7:0] addr, output logic [7:0] data, output logic valid);
        @(negedge clk);
        regReq = '{write: 1'b0, read: 1'b1, addr: addr, data: ~regReq.data};
        @(negedge clk);
        data = regReadData;
        valid = regReadValid;
        release_bus();
    endtask

    // Bright plus dark must stay above ca, so dark is raised when short
    task automatic set_ratios(input logic [7:0] bright, input logic [7:0] dark);
        if ({1'b0, bright} + {1'b0, dark} <= 9'h0ca) begin
            dark = 8'hcb - bright;
        end
        wr(ADDR_DARK_RATIO, dark);
        wr(ADDR_BRIGHT_RATIO, bright);
    endtask
endmodule
`default_nettype wire

// ==== oarb_reg_bank_tb_top.sv ====
`default_nettype none
module oarb_reg_bank_tb_top
    import oarb_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic ce = 1'b1;
    oarb_reg_req_type regReq;
    logic [7:0] regReadData;
    logic regReadValid;
    logic manualOffsetMode = 1'b0;
    logic blackCalEnable = 1'b1;
    logic rawRgbMode = 1'b0;
    logic calUpdate = 1'b0;
    logic [7:0] calLumaOffset = 8'h00;
    logic [7:0] calChromaOffset = 8'h00;
    oarb_pixel_type pixIn = '0;
    logic frameEnd = 1'b0;
    oarb_pixel_type pixOut;
    oarb_ae_dir_type aeDirection;
    logic aeDecisionValid;
    logic [1:0] crystalPowerLevel;
    logic [5:0] refVoltageSteps;
    int errorCnt = 0;
    int checks = 0;
    // 26h lies outside this slice and reads as zero
    logic [7:0] rstVal [6] = '{8'h80, 8'h80, 8'h04, 8'h33, 8'h97, 8'h00};

    oarb_reg_bank oarb_reg_bank_inst (
        .clk(clk), .reset_n(reset_n), .ce(ce), .regReq(regReq),
        .regReadData(regReadData), .regReadValid(regReadValid),
        .manualOffsetMode(manualOffsetMode), .blackCalEnable(blackCalEnable),
        .rawRgbMode(rawRgbMode), .calUpdate(calUpdate), .calLumaOffset(calLumaOffset),
        .calChromaOffset(calChromaOffset), .pixIn(pixIn), .frameEnd(frameEnd),
        .pixOut(pixOut), .aeDirection(aeDirection), .aeDecisionValid(aeDecisionValid),
        .crystalPowerLevel(crystalPowerLevel), .refVoltageSteps(refVoltageSteps)
    );

    oarb_host_model oarb_host_model_inst (
        .clk(clk), .regReq(regReq), .regReadData(regReadData), .regReadValid(regReadValid)
    );

    initial begin
        forever #4 clk = ~clk;
    end

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            errorCnt++;
            $display("ERROR t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask

    task automatic hw(input logic [7:0] addr, input logic [7:0] data);
        oarb_host_model_inst.wr(addr, data);
    endtask

    task automatic rd_chk(input logic [7:0] addr, input logic [7:0] exp);
        logic [7:0] data;
        logic valid;
        oarb_host_model_inst.rd(addr, data, valid);
        chk({7'h00, valid}, 8'h01);
        chk(data, exp);
    endtask

    task automatic ref_chk(input logic [1:0] power, input logic [5:0] steps);
        chk({6'h00, crystalPowerLevel}, {6'h00, power});
        chk({2'h0, refVoltageSteps}, {2'h0, steps});
    endtask

    task automatic cal_upd(input logic [7:0] luma, input logic [7:0] chroma);
        @(negedge clk);
        calUpdate = 1'b1;
        calLumaOffset = luma;
        calChromaOffset = chroma;
        @(negedge clk);
        calUpdate = 1'b0;
    endtask

    task automatic px(input logic [7:0] luma, input logic [7:0] chroma, input logic isU,
                      input logic [7:0] expLuma, input logic [7:0] expChroma);
        @(negedge clk);
        pixIn = '{valid: 1'b1, chromaIsU: isU, luma: luma, chroma: chroma};
        @(negedge clk);
        pixIn.valid = 1'b0;
        chk({7'h00, pixOut.valid}, 8'h01);
        chk({7'h00, pixOut.chromaIsU}, {7'h00, isU});
        chk(pixOut.luma, expLuma);
        chk(pixOut.chroma, expChroma);
    endtask

    // Leading end pulse flushes counts left over from earlier pixels
    task automatic frame(input int bright, input int dark, input oarb_ae_dir_type exp);
        @(negedge clk);
        frameEnd = 1'b1;
        @(negedge clk);
        frameEnd = 1'b0;
        for (int i = 0; i < bright + dark; i++) begin
            pixIn = '{valid: 1'b1, chromaIsU: 1'b0, luma: (i < bright) ? 8'he0 : 8'h10,
                      chroma: 8'h80};
            @(negedge clk);
        end
        pixIn.valid = 1'b0;
        frameEnd = 1'b1;
        @(negedge clk);
        frameEnd = 1'b0;
        chk({7'h00, aeDecisionValid}, 8'h01);
        chk({6'h00, aeDirection}, {6'h00, exp});
    endtask

    task automatic report_and_stop();
        $display("Comparisons %0d, mismatches %0d", checks, errorCnt);
        if (errorCnt == 0 && checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    initial begin
        repeat (3) @(negedge clk);
        reset_n = 1'b1;
        foreach (rstVal[i]) rd_chk(8'h21 + 8'(i), rstVal[i]);
        ref_chk(2'b00, 6'h2c);
        hw(ADDR_REF_CTRL, 8'hc5);
        ref_chk(2'b11, 6'h2d);
        hw(ADDR_REF_CTRL, 8'h3f);
        ref_chk(2'b00, 6'h37);
        rd_chk(ADDR_REF_CTRL, 8'h3f);
        // Frozen clock enable must drop the write
        ce = 1'b0;
        hw(ADDR_REF_CTRL, 8'haa);
        ce = 1'b1;
        rd_chk(ADDR_REF_CTRL, 8'h3f);
        hw(ADDR_BRIGHT_RATIO, 8'hff);
        rd_chk(ADDR_BRIGHT_RATIO, 8'hff);
        hw(ADDR_LUMA_OFS, 8'h85);
        hw(ADDR_CHROMA_OFS, 8'h03);
        rd_chk(ADDR_LUMA_OFS, 8'h80);
        rd_chk(ADDR_CHROMA_OFS, 8'h80);
        cal_upd(8'h12, 8'h9a);
        rd_chk(ADDR_LUMA_OFS, 8'h12);
        rd_chk(ADDR_CHROMA_OFS, 8'h9a);
        px(8'h10, 8'h50, 1'b1, 8'h22, 8'h50);
        manualOffsetMode = 1'b1;
        oarb_host_model_inst.idleCycles = 2;
        hw(ADDR_LUMA_OFS, 8'h85);
        hw(ADDR_CHROMA_OFS, 8'h03);
        cal_upd(8'h44, 8'h44);
        oarb_host_model_inst.idleCycles = 0;
        rd_chk(ADDR_LUMA_OFS, 8'h85);
        rd_chk(ADDR_CHROMA_OFS, 8'h03);
        px(8'h10, 8'h50, 1'b1, 8'h0b, 8'h50);
        hw(ADDR_LUMA_OFS, 8'h7f);
        px(8'hf0, 8'h50, 1'b1, 8'hff, 8'h50);
        hw(ADDR_LUMA_OFS, 8'hff);
        px(8'h10, 8'h50, 1'b1, 8'h00, 8'h50);
        blackCalEnable = 1'b0;
        px(8'h10, 8'h50, 1'b1, 8'h10, 8'h53);
        px(8'h10, 8'h50, 1'b0, 8'h10, 8'h50);
        rawRgbMode = 1'b1;
        px(8'h10, 8'h50, 1'b0, 8'h10, 8'h53);
        rawRgbMode = 1'b0;
        hw(ADDR_CHROMA_OFS, 8'h83);
        px(8'h10, 8'h50, 1'b1, 8'h10, 8'h4d);
        reset_n = 1'b0;
        repeat (2) @(negedge clk);
        reset_n = 1'b1;
        rd_chk(ADDR_REF_CTRL, 8'h04);
        oarb_host_model_inst.set_ratios(8'h20, 8'hc0);
        frame(10, 0, AE_DARKEN);
        frame(5, 5, AE_DARKEN);
        oarb_host_model_inst.set_ratios(8'h90, 8'h40);
        frame(5, 5, AE_STABLE);
        frame(0, 10, AE_BRIGHTEN);
        report_and_stop();
    end

    // Whole run needs well under a thousand cycles
    initial begin
        repeat (20000) @(posedge clk);
        errorCnt++;
        $display("ERROR t=%0t watchdog expired", $time);
        report_and_stop();
    end
endmodule
`default_nettype wire
